// ### hdl/dtc_pkg.sv
/*
  dtc_pkg: constants for the dual timer capture/reload block (offsets, fields, resets, enums).
  assumes an axi4-lite slave with 32-bit data, one register per aligned word.
*/
// What this block does
// - fastest internal count period is two system clock cycles
// - aux timer, core timer and capture/reload register are all software accessible
// - each timer counts on prescaled cpu clock or external input, per configuration
// - direction from software bit or external direction pin level
// - aux timer direction comes only from software, no pin
// - core toggle latch inverts on every core overflow or underflow
// - toggle latch can clock aux timer and drive toggle output pin
// - core overflow/underflow events are offered to compare unit timers
// - with reload enabled, core wrap loads capture/reload register value
// - selected capture pin edge copies aux timer into capture/reload register
// - clear-after-capture zeroes aux timer right after the capture
// - capture may also trigger on neighbour count and/or direction input edges
// - timers are 16 bits, wrapping both ways
package dtc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AUX = 8'h04;
  localparam logic [7:0] ADDR_CORE = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE_RELOAD_REG = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PRESC = 8'h14;
  // ctrl fields
  localparam int AUX_RUN_BIT = 0;
  localparam int AUX_DOWN_BIT = 1;
  localparam int AUX_SRC_LSB = 2;
  localparam int CORE_RUN_BIT = 4;
  localparam int CORE_DOWN_BIT = 5;
  localparam int CORE_EXTDIR_BIT = 6;
  localparam int CORE_SRC_LSB = 7;
  localparam int RELOAD_EN_BIT = 9;
  localparam int CLR_AFTER_CAP_BIT = 10;
  localparam int CAP_EDGE_LSB = 11;
  localparam int CAP_PIN_EN_BIT = 13;
  localparam int CAP_NCNT_EN_BIT = 14;
  localparam int CAP_NDIR_EN_BIT = 15;
  localparam int TOG_OUT_EN_BIT = 16;
  localparam int CTRL_BITS = 17;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 17'h00000;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam int MIN_COUNT_CYCLES = 2;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {SRC_PRESC, SRC_EXT, SRC_TOGGLE, SRC_OFF} dtc_src_type;
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} dtc_edge_type;
endpackage

// ### hdl/dtc_sync.sv
/*
  dtc_sync: three-flop synchroniser with edge report for one external pin.
  assumes pin is asynchronous to aclk.
*/
`timescale 1ns/10ps
module dtc_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [dtc_pkg::SYNC_STAGES-1:0] sync_q;
  logic level_q;
  logic agree;
  // only the last two stages are looked at; stage 1 may be metastable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= '0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[dtc_pkg::SYNC_STAGES-2:0], pin};
      if (agree) level_q <= sync_q[dtc_pkg::SYNC_STAGES-1];
    end
  end
  // a one-cycle glitch never makes the two stages agree, so it is dropped
  assign agree = (sync_q[dtc_pkg::SYNC_STAGES-1] == sync_q[dtc_pkg::SYNC_STAGES-2]);
  assign level = level_q;
  assign rise = agree & sync_q[dtc_pkg::SYNC_STAGES-1] & ~level_q;
  assign fall = agree & ~sync_q[dtc_pkg::SYNC_STAGES-1] & level_q;
endmodule

// ### hdl/dtc_top.sv
/*
  dtc_top: two cascadable 16-bit timers with shared capture/reload register, axi4-lite slave.
  assumes external pins asynchronous; one clock aclk, synchronous active-low reset.
*/
`timescale 1ns/10ps
module dtc_top #(
  parameter int WIDTH = 16,
  parameter int PRESC_BITS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic aux_count_input,
  input wire logic core_count_input,
  input wire logic direction_input_pin,
  input wire logic capture_input_pin,
  input wire logic neighbor_count_input,
  input wire logic neighbor_direction_input,
  output logic toggle_output_pin,
  output logic core_wrap_pulse
);
  // the register map packs each timer into one 16-bit half word
  if (WIDTH != 16) begin
    $error("dtc_top: WIDTH must be 16");
  end
  if (PRESC_BITS < 1 || PRESC_BITS > 16) begin
    $error("dtc_top: PRESC_BITS out of range");
  end

  logic [dtc_pkg::CTRL_BITS-1:0] ctrl_q;
  logic [PRESC_BITS-1:0] presc_q, pcnt_q;
  logic [WIDTH-1:0] aux_q, core_q, capture_reload_reg_q;
  logic toggle_q, wrap_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q, rresp_q;

  // external inputs: aux clk, core clk, dir, capture, neighbour count, neighbour dir
  logic [5:0] pin_v, lv_v, rise_v, fall_v;
  logic auxc_r, corec_r, dir_lv, cap_lv, cap_r, cap_f, ncnt_r, ncnt_f, ndir_r, ndir_f;
  assign pin_v = {neighbor_direction_input, neighbor_count_input, capture_input_pin, direction_input_pin,
    core_count_input, aux_count_input};
  for (genvar gi = 0; gi < 6; gi++) begin : g_sync
    dtc_sync u_dtc_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(pin_v[gi]),
      .level(lv_v[gi]),
      .rise(rise_v[gi]),
      .fall(fall_v[gi])
    );
  end
  assign auxc_r = rise_v[0];
  assign corec_r = rise_v[1];
  assign dir_lv = lv_v[2];
  assign cap_lv = lv_v[3];
  assign cap_r = rise_v[3];
  assign cap_f = fall_v[3];
  assign ncnt_r = rise_v[4];
  assign ncnt_f = fall_v[4];
  assign ndir_r = rise_v[5];
  assign ndir_f = fall_v[5];

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] & r) | (sel[1] & f);
  endfunction

  // prescaler: tick every 2*(presc+1) clocks, never faster than two cycles
  logic presc_tick;
  assign presc_tick = (pcnt_q == presc_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcnt_q <= '0;
    end else begin
      pcnt_q <= presc_tick ? '0 : pcnt_q + 1'b1;
    end
  end
  logic half_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
    end else if (presc_tick) begin
      half_q <= ~half_q;
    end
  end
  logic fast_tick;
  assign fast_tick = presc_tick & half_q;

  // configuration decode
  logic [1:0] aux_src, core_src, cap_edge;
  assign aux_src = ctrl_q[dtc_pkg::AUX_SRC_LSB +: 2];
  assign core_src = ctrl_q[dtc_pkg::CORE_SRC_LSB +: 2];
  assign cap_edge = ctrl_q[dtc_pkg::CAP_EDGE_LSB +: 2];

  // toggle latch edges used as aux clock
  logic toggle_prev_q;
  logic toggle_edge;
  assign toggle_edge = toggle_q ^ toggle_prev_q;

  logic core_step, aux_step;
  assign core_step = ctrl_q[dtc_pkg::CORE_RUN_BIT] &
    ((core_src == dtc_pkg::SRC_PRESC) ? fast_tick :
     (core_src == dtc_pkg::SRC_EXT) ? corec_r : 1'b0);
  assign aux_step = ctrl_q[dtc_pkg::AUX_RUN_BIT] &
    ((aux_src == dtc_pkg::SRC_PRESC) ? fast_tick :
     (aux_src == dtc_pkg::SRC_EXT) ? auxc_r :
     (aux_src == dtc_pkg::SRC_TOGGLE) ? toggle_edge : 1'b0);

  logic core_down, aux_down;
  assign core_down = ctrl_q[dtc_pkg::CORE_EXTDIR_BIT] ? dir_lv : ctrl_q[dtc_pkg::CORE_DOWN_BIT];
  assign aux_down = ctrl_q[dtc_pkg::AUX_DOWN_BIT];

  logic core_wrap;
  assign core_wrap = core_step & (core_down ? (core_q == '0) : (core_q == '1));

  logic cap_event;
  assign cap_event = (ctrl_q[dtc_pkg::CAP_PIN_EN_BIT] & edge_hit(cap_edge, cap_r, cap_f)) |
    (ctrl_q[dtc_pkg::CAP_NCNT_EN_BIT] & edge_hit(cap_edge, ncnt_r, ncnt_f)) |
    (ctrl_q[dtc_pkg::CAP_NDIR_EN_BIT] & edge_hit(cap_edge, ndir_r, ndir_f));

  // mapped-register decode shared by both channels
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == dtc_pkg::ADDR_CTRL) || (a == dtc_pkg::ADDR_AUX) || (a == dtc_pkg::ADDR_CORE) ||
      (a == dtc_pkg::ADDR_CAPTURE_RELOAD_REG) || (a == dtc_pkg::ADDR_STATUS) || (a == dtc_pkg::ADDR_PRESC);
  endfunction

  // bus write decode
  logic wr_fire;
  assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  logic wr_ctrl, wr_aux, wr_core, wr_capture_reload_reg, wr_presc, wr_ok;
  assign wr_ctrl = wr_fire & (awaddr_q == dtc_pkg::ADDR_CTRL);
  assign wr_aux = wr_fire & (awaddr_q == dtc_pkg::ADDR_AUX);
  assign wr_core = wr_fire & (awaddr_q == dtc_pkg::ADDR_CORE);
  assign wr_capture_reload_reg = wr_fire & (awaddr_q == dtc_pkg::ADDR_CAPTURE_RELOAD_REG);
  assign wr_presc = wr_fire & (awaddr_q == dtc_pkg::ADDR_PRESC);
  assign wr_ok = reg_hit(awaddr_q);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [31:0] ctrl_w, aux_w, core_w, cap_w, presc_w;
  assign ctrl_w = merge({15'h0000, ctrl_q}, wdata_q, wstrb_q);
  assign aux_w = merge({16'h0000, aux_q}, wdata_q, wstrb_q);
  assign core_w = merge({16'h0000, core_q}, wdata_q, wstrb_q);
  assign cap_w = merge({16'h0000, capture_reload_reg_q}, wdata_q, wstrb_q);
  assign presc_w = merge({{(32-PRESC_BITS){1'b0}}, presc_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= dtc_pkg::CTRL_RESET;
      presc_q <= PRESC_BITS'(dtc_pkg::PRESC_RESET);
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_w[dtc_pkg::CTRL_BITS-1:0];
      if (wr_presc) presc_q <= presc_w[PRESC_BITS-1:0];
    end
  end

  // core timer: software write beats reload beats count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_q <= dtc_pkg::TIMER_RESET;
    end else if (wr_core) begin
      core_q <= core_w[WIDTH-1:0];
    end else if (core_wrap && ctrl_q[dtc_pkg::RELOAD_EN_BIT]) begin
      core_q <= capture_reload_reg_q;
    end else if (core_step) begin
      core_q <= core_down ? core_q - 1'b1 : core_q + 1'b1;
    end
  end

  // aux timer: capture clear overrides a coincident count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_q <= dtc_pkg::TIMER_RESET;
    end else if (wr_aux) begin
      aux_q <= aux_w[WIDTH-1:0];
    end else if (cap_event && ctrl_q[dtc_pkg::CLR_AFTER_CAP_BIT]) begin
      aux_q <= '0;
    end else if (aux_step) begin
      aux_q <= aux_down ? aux_q - 1'b1 : aux_q + 1'b1;
    end
  end

  // capture wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reload_reg_q <= dtc_pkg::TIMER_RESET;
    end else if (cap_event) begin
      capture_reload_reg_q <= aux_q;
    end else if (wr_capture_reload_reg) begin
      capture_reload_reg_q <= cap_w[WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_q <= 1'b0;
      toggle_prev_q <= 1'b0;
      wrap_q <= 1'b0;
      toggle_output_pin <= 1'b0;
    end else begin
      if (core_wrap) toggle_q <= ~toggle_q;
      toggle_prev_q <= toggle_q;
      wrap_q <= core_wrap;
      toggle_output_pin <= ctrl_q[dtc_pkg::TOG_OUT_EN_BIT] & toggle_q;
    end
  end
  assign core_wrap_pulse = wrap_q;

  // axi4-lite write channel: address and data accepted in either order
  // readies stay low until the response is taken, so one write at a time
  assign s_axi_awready = ~aw_got_q;
  assign s_axi_wready = ~w_got_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read channel
  logic [7:0] rd_addr;
  assign rd_addr = {s_axi_araddr[7:2], 2'h0};
  logic [31:0] rd_mux;
  logic rd_hit;
  assign rd_hit = reg_hit(rd_addr);
  assign rd_mux = (rd_addr == dtc_pkg::ADDR_CTRL) ? {15'h0000, ctrl_q} :
    (rd_addr == dtc_pkg::ADDR_AUX) ? {16'h0000, aux_q} :
    (rd_addr == dtc_pkg::ADDR_CORE) ? {16'h0000, core_q} :
    (rd_addr == dtc_pkg::ADDR_CAPTURE_RELOAD_REG) ? {16'h0000, capture_reload_reg_q} :
    (rd_addr == dtc_pkg::ADDR_STATUS) ? {28'h0000000, dir_lv, cap_lv, toggle_output_pin, toggle_q} :
    (rd_addr == dtc_pkg::ADDR_PRESC) ? {{(32-PRESC_BITS){1'b0}}, presc_q} : 32'h00000000;
  assign s_axi_arready = ~rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? 2'h0 : 2'h2;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// ### testbench/dtc_pins.sv
/*
  dtc_pins: external event pins and neighbour timer inputs seen by the block.
  assumes the bench calls put or pulse; pins keep their level between calls.
*/
`timescale 1ns/10ps
module dtc_pins (
  input wire logic aclk,
  output logic aux_count_input,
  output logic core_count_input,
  output logic direction_input_pin,
  output logic capture_input_pin,
  output logic neighbor_count_input,
  output logic neighbor_direction_input
);
  logic [5:0] lv_q = 6'h00;
  // plain levels, no relation to aclk phase needed by the block
  assign {neighbor_direction_input, neighbor_count_input, capture_input_pin, direction_input_pin, core_count_input,
    aux_count_input} = lv_q;
  task put(input int i, input logic v);
    @(posedge aclk);
    lv_q[i] <= v;
  endtask
  task pulse(input int i);
    put(i, 1'b1);
    repeat (8) @(posedge aclk);
    put(i, 1'b0);
    repeat (8) @(posedge aclk);
  endtask
endmodule

// ### testbench/dtc_top_monitor.sv
/*
  dtc_top_monitor: bus handshake and wrap pulse checks on dtc_top ports.
  assumes one clock aclk and synchronous active-low aresetn.
*/
`timescale 1ns/10ps
module dtc_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_wrap_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_B_SOON: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
  AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while write pending");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("unmapped read returned data");
  // two clocks per tick at the fastest, so a wrap never repeats back to back
  AST_WRAP_GAP: assert property (core_wrap_pulse |=> !core_wrap_pulse)
    else $error("wrap pulses too close");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (core_wrap_pulse);
endmodule
bind dtc_top dtc_top_monitor u_dtc_top_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_wrap_pulse);

// ### testbench/dtc_top_tb.sv
/*
  dtc_top_tb: register, external clock, capture and core wrap scenarios.
  assumes dtc_pins drives every external pin of the block.
*/
`timescale 1ns/10ps
module dtc_top_tb;
  localparam logic [7:0] A_CTRL = dtc_pkg::ADDR_CTRL;
  localparam logic [7:0] A_AUX = dtc_pkg::ADDR_AUX;
  localparam logic [7:0] A_CORE = dtc_pkg::ADDR_CORE;
  localparam logic [7:0] A_CAP = dtc_pkg::ADDR_CAPTURE_RELOAD_REG;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, toggle_output_pin, core_wrap_pulse;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic aux_count_input, core_count_input, direction_input_pin, capture_input_pin;
  logic neighbor_count_input, neighbor_direction_input;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  dtc_top u_dtc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_count_input, .core_count_input,
    .direction_input_pin, .capture_input_pin, .neighbor_count_input, .neighbor_direction_input,
    .toggle_output_pin, .core_wrap_pulse);
  dtc_pins u_dtc_pins (.aclk, .aux_count_input, .core_count_input, .direction_input_pin, .capture_input_pin,
    .neighbor_count_input, .neighbor_direction_input);
  task summarize;
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // each bus task starts one edge late so a release never meets a new request
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, rv);
  endtask
  task wp;
    do @(posedge aclk); while (!core_wrap_pulse);
  endtask
  task t_regs;
    for (int i = 0; i < 6; i++) begin
      rchk(8'(i * 4), 32'h0, "reset value");
    end
    wr(A_AUX, 32'h1234);
    rchk(A_AUX, 32'h1234, "aux readback");
    wr(dtc_pkg::ADDR_PRESC, 32'h1ff);
    rchk(dtc_pkg::ADDR_PRESC, 32'hff, "presc width");
    wr(dtc_pkg::ADDR_PRESC, 32'h0);
    wr(8'h20, 32'h5);
    chk("bresp unmapped", 32'h2, {30'h0, rr});
    rchk(8'h20, 32'h0, "rdata unmapped");
    chk("rresp unmapped", 32'h2, {30'h0, rr});
  endtask
  task t_ext;
    wr(A_AUX, 32'h0);
    wr(A_CORE, 32'h0);
    wr(A_CTRL, 32'h95);
    for (int i = 0; i < 3; i++) begin
      u_dtc_pins.pulse(0);
      u_dtc_pins.pulse(1);
    end
    wr(A_CTRL, 32'h0);
    rchk(A_AUX, 32'h3, "aux ext count");
    rchk(A_CORE, 32'h3, "core ext count");
  endtask
  task t_cap;
    wr(A_AUX, 32'ha5);
    wr(A_CTRL, 32'h2c0c);
    u_dtc_pins.put(3, 1'b1);
    repeat (8) @(posedge aclk);
    rchk(A_CAP, 32'ha5, "capture rise");
    rchk(A_AUX, 32'h0, "aux cleared");
    rchk(dtc_pkg::ADDR_STATUS, 32'h4, "status capture pin");
    wr(A_AUX, 32'h33);
    u_dtc_pins.put(3, 1'b0);
    repeat (8) @(posedge aclk);
    rchk(A_CAP, 32'ha5, "fall ignored");
    wr(A_CTRL, 32'h580c);
    u_dtc_pins.pulse(4);
    rchk(A_CAP, 32'h33, "neighbour count capture");
    wr(A_AUX, 32'h77);
    wr(A_CTRL, 32'h980c);
    u_dtc_pins.put(5, 1'b1);
    repeat (8) @(posedge aclk);
    rchk(A_CAP, 32'h77, "neighbour dir capture");
  endtask
  task t_core;
    int n;
    logic t1;
    wr(A_CAP, 32'hfffe);
    wr(A_CORE, 32'hfffe);
    wr(A_AUX, 32'h0);
    wr(A_CTRL, 32'h10219);
    wp;
    t1 = toggle_output_pin;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!core_wrap_pulse);
    chk("wrap period", 32'(2 * dtc_pkg::MIN_COUNT_CYCLES), n);
    chk("toggle pin", {31'h0, ~t1}, {31'h0, toggle_output_pin});
    wr(dtc_pkg::ADDR_PRESC, 32'h1);
    wp;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!core_wrap_pulse);
    chk("wrap period presc", 32'(4 * dtc_pkg::MIN_COUNT_CYCLES), n);
    wr(dtc_pkg::ADDR_PRESC, 32'h0);
    wr(A_CTRL, 32'h0);
    rd(A_CORE);
    chk("core reload", 32'h7fff, rv >> 1);
    rd(A_AUX);
    chk("aux from latch", 32'h1, {31'h0, rv != 32'h0});
  endtask
  task t_down;
    u_dtc_pins.put(2, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(A_CORE, 32'h0);
      wr(A_AUX, 32'h0);
      wr(A_CTRL, i == 0 ? 32'h33 : 32'h51);
      wp;
      wr(A_CTRL, 32'h0);
      rd(A_CORE);
      chk("core underflow", 32'hfff, rv >> 4);
      rd(A_AUX);
      chk("aux software direction", i == 0 ? 32'hfff : 32'h0, rv >> 4);
      chk("toggle pin off", 32'h0, {31'h0, toggle_output_pin});
    end
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_ext;
    t_cap;
    t_core;
    t_down;
    summarize;
  end
endmodule
